// ### src/fpx_pkg.sv
// Shared constants and types for the floating-point exception and mode logic
package fpx_pkg;

   // ----------------------------------------------------------------
   // Status/control register layout
   // ----------------------------------------------------------------
   localparam int FPX_BANK_POS = 21;            // Register bank select
   localparam int FPX_SIZE_POS = 20;            // Pair transfer size
   localparam int FPX_PREC_POS = 19;            // Precision mode
   localparam int FPX_DNRM_POS = 18;            // Denormal flush mode
   localparam int FPX_CAUSE_HI = 17;            // Cause E
   localparam int FPX_CAUSE_LO = 12;            // Cause I
   localparam int FPX_EN_HI = 11;               // Enable V
   localparam int FPX_EN_LO = 7;                // Enable I
   localparam int FPX_FLAG_HI = 6;              // Flag V
   localparam int FPX_FLAG_LO = 2;              // Flag I
   localparam int FPX_RND_HI = 1;               // Rounding field
   localparam int FPX_RND_LO = 0;
   localparam logic [31:0] FPX_RESET = 32'h0004_0001;    // Value after reset
   localparam logic [31:0] FPX_WR_MASK = 32'h003F_FFFF;  // Bits 31..22 read as zero

   // Source order inside the five-bit enable and flag fields
   localparam int FPX_SRC_V = 4;
   localparam int FPX_SRC_Z = 3;
   localparam int FPX_SRC_O = 2;
   localparam int FPX_SRC_U = 1;
   localparam int FPX_SRC_I = 0;

   // Rounding codes
   localparam logic [1:0] FPX_RND_NEAREST = 2'h0;
   localparam logic [1:0] FPX_RND_ZERO = 2'h1;

   // ----------------------------------------------------------------
   // Single-precision special values and approximation bound
   // ----------------------------------------------------------------
   localparam logic [30:0] FPX_QNAN = 31'h7FC0_0000;
   localparam logic [30:0] FPX_INF = 31'h7F80_0000;
   localparam logic [30:0] FPX_MAX_NORM = 31'h7F7F_FFFF;
   localparam int FPX_DIGITS_NORM = 24;         // Significant digits, normalized
   localparam int FPX_DIGITS_DENORM = 23;       // Significant digits, denormalized

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int FPX_LOAD_CYCLES = 4;          // Control load settle, 4 cycles

   // Instruction classes seen by this block
   typedef enum logic [3:0] {
      FPX_OP_ARITH,
      FPX_OP_DIVIDE,
      FPX_OP_INNER_PRODUCT,
      FPX_OP_TRANSFORM,
      FPX_OP_BANK_TOGGLE,
      FPX_OP_SIZE_TOGGLE,
      FPX_OP_CONTROL_LOAD,
      FPX_OP_FLOAT_MOVE
   } fpx_op_type;

endpackage : fpx_pkg

// ### src/fpx_default_result.sv
// Default-result generator used when exception handling is disabled
`timescale 1ns/1ps
module fpx_default_result
   import fpx_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic write_req,           // Destination write wanted
   input wire logic invalid,
   input wire logic divzero,
   input wire logic overflow,
   input wire logic underflow,
   input wire logic sign,                // Sign of the unrounded value
   input wire logic [1:0] rounding_field,
   input wire logic denormal_flush_mode,
   input wire logic [31:0] raw_result,   // Rounded datapath result
   output logic result_write,
   output logic [31:0] result
);

   // ----------------------------------------------------------------
   // Selection
   // ----------------------------------------------------------------
   wire logic rz_mode = (rounding_field == FPX_RND_ZERO);
   // Underflow keeps datapath denormal unless flushing to zero
   wire logic [30:0] under_mag = denormal_flush_mode ? 31'h0000_0000 : raw_result[30:0];
   wire logic [30:0] over_mag = rz_mode ? FPX_MAX_NORM : FPX_INF;
   wire logic [31:0] next_result =
      invalid   ? {1'b0, FPX_QNAN} :
      divzero   ? {sign, FPX_INF} :
      overflow  ? {sign, over_mag} :
      underflow ? {sign, under_mag} : raw_result;

   // Registered data output
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         result_write <= 1'b0;
         result <= 32'h0000_0000;
      end else begin
         result_write <= write_req;
         result <= next_result;
      end
   end

endmodule : fpx_default_result

// ### src/fpx_load_delay.sv
// Settling delay for a control load into the status/control register
`timescale 1ns/1ps
module fpx_load_delay
   import fpx_pkg::*;
#(
   parameter int CYCLES = FPX_LOAD_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic start,               // Control load accepted
   input wire logic [31:0] load_data,
   output logic busy,                    // Load in progress
   output logic commit,                  // One-cycle pulse, value takes effect
   output logic [31:0] held_data
);

   typedef enum logic {FPX_LD_IDLE, FPX_LD_WAIT} fpx_ld_type;

   fpx_ld_type state;                    // Delay state
   logic [3:0] count;                    // Cycles remaining

   wire logic last = (state == FPX_LD_WAIT) && (count == 4'h1);

   assign busy = (state == FPX_LD_WAIT);
   assign commit = last;

   // Count down from acceptance to commit
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         state <= FPX_LD_IDLE;
         count <= 4'h0;
         held_data <= 32'h0000_0000;
      end else begin
         case (state)
            FPX_LD_IDLE: begin
               if (start) begin
                  state <= FPX_LD_WAIT;
                  count <= 4'(CYCLES);
                  held_data <= load_data;
               end
            end
            FPX_LD_WAIT: begin
               count <= count - 4'h1;
               if (last) begin
                  state <= FPX_LD_IDLE;
               end
            end
            default: state <= FPX_LD_IDLE;
         endcase
      end
   end

endmodule : fpx_load_delay

// ### src/fpx_exception_unit.sv
// Exception detection, status bookkeeping and mode bits of the FPU
`timescale 1ns/1ps

// What this block does
// (RULE_01) FPU disabled: raise illegal or slot illegal
// (RULE_02) Denormal input without flush raises error source
// (RULE_03) Inexact on overflow, underflow or rounding
// (RULE_04) Cause six bits; error source unmaskable
// (RULE_05) Occurring source sets cause and flag
// (RULE_06) Absent source clears cause, keeps flag
// (RULE_07) Invalid trap: enabled and transform or invalid
// (RULE_08) Zero-divide trap when enabled and divisor zero
// (RULE_09) O/U/I trap on mere possibility when enabled
// (RULE_10) One shared exception event to the core
// (RULE_11) Trapped instruction leaves destination untouched
// (RULE_12) Possibility-only trap leaves cause field zero
// (RULE_13) Untrapped invalid gives quiet NaN, sets flag
// (RULE_14) Untrapped divide by zero gives signed infinity
// (RULE_15) Overflow: max normal toward zero, else infinity
// (RULE_16) Underflow: denormal or zero, flush gives zero
// (RULE_17) Inner product always sets inexact, may trap
// (RULE_18) Transform always sets inexact, may trap
// (RULE_19) Transform traps whenever invalid enabled
// (RULE_20) Bank toggle one cycle; control load waits
// (RULE_21) Size bit set: moves carry two words
// (RULE_22) Size toggle inverts transfer size bit
// (RULE_23) Geometric approximation within digit bound
// (RULE_24) Cause bits at 17 down to 12
// (RULE_25) Enable bits at 11 down to 7
// (RULE_26) Flag bits at 6 down to 2
// (RULE_27) Rounding 00 nearest, 01 toward zero
module fpx_exception_unit
   import fpx_pkg::*;
#(
   parameter int LOAD_CYCLES = FPX_LOAD_CYCLES
)
(
   input wire logic ref_clk,
   input wire logic reset,
   // Issue from the core
   input wire logic op_valid,
   input wire fpx_op_type op_class,
   input wire logic op_in_delay_slot,
   input wire logic fpu_disable_bit,     // From cpu_status_reg
   input wire logic [31:0] load_data,    // Control load value
   // Datapath observations for the issued operation
   input wire logic src_denormal_in,
   input wire logic src_invalid,
   input wire logic src_divzero,
   input wire logic src_overflow,
   input wire logic src_underflow,
   input wire logic src_rounded,
   input wire logic can_overflow,
   input wire logic can_underflow,
   input wire logic can_inexact,
   input wire logic writes_dest,
   input wire logic result_sign,
   input wire logic [31:0] raw_result,
   // Answers to the core
   output logic busy,
   output logic illegal_exc,
   output logic slot_illegal_exc,
   output logic fpu_exc,
   output logic dest_write,
   output logic [31:0] dest_value,
   output logic move_pair,
   output logic move_done,
   // Register state
   output logic [31:0] fpu_status_control_reg,
   output logic bank_select_bit,
   output logic pair_transfer_size_bit,
   output logic denormal_flush_mode,
   output logic [1:0] rounding_field
);

   // ----------------------------------------------------------------
   // Decode
   // ----------------------------------------------------------------
   logic [31:0] csr;                     // Status/control register
   logic load_busy;
   logic load_commit;
   logic [31:0] load_held;

   // True when the class names an arithmetic-type operation
   function automatic logic is_compute(input fpx_op_type c);
      return (c == FPX_OP_ARITH) || (c == FPX_OP_DIVIDE) ||
             (c == FPX_OP_INNER_PRODUCT) || (c == FPX_OP_TRANSFORM);
   endfunction : is_compute

   wire logic accept = op_valid && !load_busy;
   wire logic blocked = accept && fpu_disable_bit;                     // [RULE_01]
   wire logic run = accept && !fpu_disable_bit;
   wire logic run_compute = run && is_compute(op_class);
   wire logic is_inner = (op_class == FPX_OP_INNER_PRODUCT);
   wire logic is_transform = (op_class == FPX_OP_TRANSFORM);
   wire logic is_approx = is_inner || is_transform;                    // [RULE_23]

   // Current fields
   wire logic [4:0] enable = csr[FPX_EN_HI:FPX_EN_LO];                 // [RULE_25]
   wire logic [4:0] flags = csr[FPX_FLAG_HI:FPX_FLAG_LO];              // [RULE_26]
   wire logic dn_mode = csr[FPX_DNRM_POS];

   // ----------------------------------------------------------------
   // Source detection
   // ----------------------------------------------------------------
   wire logic occ_e = src_denormal_in && !dn_mode;                     // [RULE_02]
   wire logic occ_v = src_invalid;
   wire logic occ_z = src_divzero;
   wire logic occ_o = src_overflow;
   wire logic occ_u = src_underflow;
   // Approximate geometric operations are always inexact
   wire logic occ_i = src_overflow || src_underflow || src_rounded ||
                      is_approx; // [RULE_03] [RULE_17] [RULE_18]
   wire logic [5:0] next_cause = {occ_e, occ_v, occ_z, occ_o, occ_u, occ_i}; // [RULE_04] [RULE_24]
   wire logic [4:0] flag_set = run_compute ? next_cause[4:0] : 5'h00;

   // ----------------------------------------------------------------
   // Trap decision
   // ----------------------------------------------------------------
   wire logic trap_v = enable[FPX_SRC_V] && (is_transform || occ_v);  // [RULE_07] [RULE_19]
   wire logic trap_z = enable[FPX_SRC_Z] && occ_z;                     // [RULE_08]
   wire logic trap_o = enable[FPX_SRC_O] && can_overflow;              // [RULE_09]
   wire logic trap_u = enable[FPX_SRC_U] && can_underflow;             // [RULE_09]
   wire logic trap_i = enable[FPX_SRC_I] && (can_inexact || is_approx);   // [RULE_09] [RULE_17]
   // Error source has no enable bit and always traps
   wire logic trap_any = occ_e || trap_v || trap_z || trap_o || trap_u || trap_i;   // [RULE_04]
   wire logic take_exc = run_compute && trap_any;

   // ----------------------------------------------------------------
   // Next register value
   // ----------------------------------------------------------------
   logic [31:0] next_csr;

   // Cause replaced each arithmetic-type operation, flags sticky, toggles invert
   always_comb begin
      next_csr = csr;
      if (load_commit) begin
         next_csr = load_held & FPX_WR_MASK;
      end
      if (run_compute) begin
         next_csr[FPX_CAUSE_HI:FPX_CAUSE_LO] = next_cause; // [RULE_05] [RULE_06] [RULE_12]
      end
      // Hardware set wins over a clearing load
      next_csr[FPX_FLAG_HI:FPX_FLAG_LO] =
         next_csr[FPX_FLAG_HI:FPX_FLAG_LO] | flag_set;                  // [RULE_05] [RULE_13]
      if (run && op_class == FPX_OP_BANK_TOGGLE) begin
         next_csr[FPX_BANK_POS] = !csr[FPX_BANK_POS];                   // [RULE_20]
      end
      if (run && op_class == FPX_OP_SIZE_TOGGLE) begin
         next_csr[FPX_SIZE_POS] = !csr[FPX_SIZE_POS];                   // [RULE_22]
      end
   end

   // Status/control register
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         csr <= FPX_RESET;
      end else begin
         csr <= next_csr;
      end
   end

   // ----------------------------------------------------------------
   // Exception and move answers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         illegal_exc <= 1'b0;
         slot_illegal_exc <= 1'b0;
         fpu_exc <= 1'b0;
         move_done <= 1'b0;
         move_pair <= 1'b0;
      end else begin
         illegal_exc <= blocked && !op_in_delay_slot;                   // [RULE_01]
         slot_illegal_exc <= blocked && op_in_delay_slot;               // [RULE_01]
         fpu_exc <= take_exc;                                           // [RULE_10]
         move_done <= run && op_class == FPX_OP_FLOAT_MOVE;
         move_pair <= run && op_class == FPX_OP_FLOAT_MOVE && csr[FPX_SIZE_POS];   // [RULE_21]
      end
   end

   // ----------------------------------------------------------------
   // Submodules
   // ----------------------------------------------------------------
   // Default results; no write when the trap is taken
   fpx_default_result u_default (
      .ref_clk(ref_clk),
      .reset(reset),
      .write_req(run_compute && writes_dest && !trap_any),             // [RULE_11]
      .invalid(occ_v),                                                  // [RULE_13]
      .divzero(occ_z),                                                  // [RULE_14]
      .overflow(occ_o),                                                 // [RULE_15]
      .underflow(occ_u),                                                // [RULE_16]
      .sign(result_sign),
      .rounding_field(csr[FPX_RND_HI:FPX_RND_LO]),                      // [RULE_27]
      .denormal_flush_mode(dn_mode),
      .raw_result(raw_result),
      .result_write(dest_write),
      .result(dest_value)
   );

   // Control load settles before it takes effect
   fpx_load_delay #(.CYCLES(LOAD_CYCLES)) u_load (
      .ref_clk(ref_clk),
      .reset(reset),
      .start(run && op_class == FPX_OP_CONTROL_LOAD),                  // [RULE_20]
      .load_data(load_data),
      .busy(load_busy),
      .commit(load_commit),
      .held_data(load_held)
   );

   // ----------------------------------------------------------------
   // Output wiring
   // ----------------------------------------------------------------
   assign busy = load_busy;
   assign fpu_status_control_reg = csr;
   assign bank_select_bit = csr[FPX_BANK_POS];
   assign pair_transfer_size_bit = csr[FPX_SIZE_POS];
   assign denormal_flush_mode = csr[FPX_DNRM_POS];
   assign rounding_field = csr[FPX_RND_HI:FPX_RND_LO];

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   sequence s_blocked_op;
      blocked;
   endsequence

   a_disable_illegal: assert property (s_blocked_op |=>    // [RULE_01]
      (illegal_exc || slot_illegal_exc) && !fpu_exc && !dest_write)
      else $error("disabled FPU op not refused");

   a_error_source: assert property (run_compute && src_denormal_in && !dn_mode    // [RULE_02]
      |=> fpu_exc && csr[FPX_CAUSE_HI])
      else $error("error source missed");

   a_flag_sticky: assert property (!load_commit && |flags    // [RULE_05]
      |=> (flags & $past(flags)) == $past(flags))
      else $error("flag bit lost");

   a_cause_clear: assert property (run_compute && !src_divzero    // [RULE_06]
      |=> !csr[FPX_CAUSE_LO + 3])
      else $error("zero-divide cause not cleared");

   a_zero_trap: assert property (run_compute && enable[FPX_SRC_Z] && src_divzero    // [RULE_08]
      |=> fpu_exc && !dest_write)
      else $error("zero-divide trap missed");

   a_transform_trap: assert property (run && is_transform && enable[FPX_SRC_V]    // [RULE_19]
      |=> fpu_exc && !csr[FPX_CAUSE_LO + 4] == !$past(src_invalid))
      else $error("transform trap wrong");

   a_approx_inexact: assert property (run && is_approx |=> csr[FPX_CAUSE_LO]    // [RULE_17]
      && csr[FPX_FLAG_LO])
      else $error("geometric op left inexact clear");

   a_overflow_default: assert property (run_compute && writes_dest && !trap_any    // [RULE_15]
      && !src_invalid && !src_divzero && src_overflow && rounding_field == FPX_RND_ZERO
      |=> dest_write && dest_value[30:0] == FPX_MAX_NORM)
      else $error("overflow default wrong");

   a_bank_toggle: assert property (run && op_class == FPX_OP_BANK_TOGGLE    // [RULE_20]
      && !load_commit |=> bank_select_bit != $past(bank_select_bit))
      else $error("bank toggle not one cycle");

   a_load_delay: assert property (run && op_class == FPX_OP_CONTROL_LOAD    // [RULE_20]
      |=> busy [*3] ##1 (busy && load_commit) ##1 !busy)
      else $error("control load timing wrong");

   a_size_toggle: assert property (run && op_class == FPX_OP_SIZE_TOGGLE    // [RULE_22]
      && !load_commit |=> pair_transfer_size_bit != $past(pair_transfer_size_bit))
      else $error("size toggle failed");

endmodule : fpx_exception_unit

// ### dv/fpx_core_model.sv
// Core model that issues floating-point instructions to the exception unit
`timescale 1ns/1ps
module fpx_core_model
   import fpx_pkg::*;
(
   input wire logic ref_clk,
   input wire logic busy,
   output logic op_valid,
   output fpx_op_type op_class,
   output logic op_in_delay_slot,
   output logic fpu_disable_bit,
   output logic [31:0] load_data,
   output logic src_denormal_in,
   output logic src_invalid,
   output logic src_divzero,
   output logic src_overflow,
   output logic src_underflow,
   output logic src_rounded,
   output logic can_overflow,
   output logic can_underflow,
   output logic can_inexact,
   output logic writes_dest,
   output logic result_sign,
   output logic [31:0] raw_result
);
   // ----------------------------------------------------------------
   // Issue side
   // ----------------------------------------------------------------
   // Quiet bus at time zero
   initial begin
      op_valid = 1'b0;
      op_class = FPX_OP_ARITH;
      {fpu_disable_bit, op_in_delay_slot, src_denormal_in, src_invalid, src_divzero,
       src_overflow, src_underflow, src_rounded, can_overflow, can_underflow,
       can_inexact, writes_dest} = 12'h000;
      result_sign = 1'b0;
      raw_result = 32'h0000_0000;
      load_data = 32'h0000_0000;
   end

   // Offer one instruction, hold it while busy, return after the taking edge
   task automatic issue(input fpx_op_type c, input logic [11:0] f, input logic s,
                        input logic [31:0] r, input logic [31:0] ld);
      op_valid = 1'b1;
      op_class = c;
      {fpu_disable_bit, op_in_delay_slot, src_denormal_in, src_invalid, src_divzero,
       src_overflow, src_underflow, src_rounded, can_overflow, can_underflow,
       can_inexact, writes_dest} = f;
      result_sign = s;
      raw_result = r;
      load_data = ld;
      while (busy === 1'b1) @(negedge ref_clk);
      @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : issue

   // Release: data lines no longer hold their last value
   task automatic idle();
      op_valid = 1'b0;
      raw_result = ~raw_result;
      load_data = ~load_data;
   endtask : idle
endmodule : fpx_core_model

// ### dv/fpx_exception_unit_tb.sv
// Self-checking bench for the FPU exception and mode logic
`timescale 1ns/1ps
module fpx_exception_unit_tb
   import fpx_pkg::*;
;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam int LC = 4;                   // Control load settle cycles
   logic ref_clk, reset, op_valid, op_in_delay_slot, fpu_disable_bit;
   logic src_denormal_in, src_invalid, src_divzero, src_overflow, src_underflow;
   logic src_rounded, can_overflow, can_underflow, can_inexact, writes_dest, result_sign;
   logic busy, illegal_exc, slot_illegal_exc, fpu_exc, dest_write, move_pair, move_done;
   logic bank_select_bit, pair_transfer_size_bit, denormal_flush_mode;
   logic [1:0] rounding_field;
   logic [31:0] load_data, raw_result, dest_value, fpu_status_control_reg;
   fpx_op_type op_class;
   logic [4:0] pulses;                      // One-cycle answers except move_pair
   logic [69:0] notes[$];                   // Expected outcomes, oldest first
   logic [31:0] scr;                        // Shadow of the status/control value
   logic took_d;                            // An op was taken at the last edge
   int failures, cmp_count, seed;

   assign pulses = {illegal_exc, slot_illegal_exc, fpu_exc, dest_write, move_done};

   fpx_exception_unit #(.LOAD_CYCLES(LC)) DUT (
      .ref_clk, .reset, .op_valid, .op_class, .op_in_delay_slot, .fpu_disable_bit,
      .load_data, .src_denormal_in, .src_invalid, .src_divzero, .src_overflow,
      .src_underflow, .src_rounded, .can_overflow, .can_underflow, .can_inexact,
      .writes_dest, .result_sign, .raw_result, .busy, .illegal_exc, .slot_illegal_exc,
      .fpu_exc, .dest_write, .dest_value, .move_pair, .move_done, .fpu_status_control_reg,
      .bank_select_bit, .pair_transfer_size_bit, .denormal_flush_mode, .rounding_field);

   fpx_core_model core (
      .ref_clk, .busy, .op_valid, .op_class, .op_in_delay_slot, .fpu_disable_bit,
      .load_data, .src_denormal_in, .src_invalid, .src_divzero, .src_overflow,
      .src_underflow, .src_rounded, .can_overflow, .can_underflow, .can_inexact,
      .writes_dest, .result_sign, .raw_result);

   // ----------------------------------------------------------------
   // Clock, compare and verdict
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic chk(input string what, input logic [63:0] e, input logic [63:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", what, e, g);
      end
   endtask : chk

   task give_verdict;
      $display("Comparisons %0d, failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : give_verdict

   // ----------------------------------------------------------------
   // Expected outcome of one op: {ill, slot, exc, write, move, pair, value, reg}
   // ----------------------------------------------------------------
   task automatic run_op(input fpx_op_type c, input logic [11:0] f, input logic s,
                         input logic [31:0] r);
      logic geo, ar, trap;
      logic [5:0] cause;
      logic [4:0] en;
      logic [69:0] e;
      geo = (c == FPX_OP_INNER_PRODUCT) || (c == FPX_OP_TRANSFORM);
      ar = geo || (c == FPX_OP_ARITH) || (c == FPX_OP_DIVIDE);
      en = scr[FPX_EN_HI:FPX_EN_LO];
      e = '0;
      if (f[11]) begin
         e[69:68] = f[10] ? 2'b01 : 2'b10;
      end else begin
         if (ar) begin
            cause = {f[9] & ~scr[FPX_DNRM_POS], f[8:5], |f[6:4] | geo};
            trap = cause[5] | (en[4] & (f[8] | (c == FPX_OP_TRANSFORM))) | (en[3] & f[7])
               | (en[2] & f[3]) | (en[1] & f[2]) | (en[0] & (f[1] | geo));
            scr[17:12] = cause;
            scr[6:2] = scr[6:2] | cause[4:0];
            e[67] = trap;
            e[66] = f[0] & ~trap;
            e[63:32] = f[8] ? {s, FPX_QNAN} : f[7] ? {s, FPX_INF}
               : f[6] ? ((scr[1:0] == FPX_RND_ZERO) ? {s, FPX_MAX_NORM} : {s, FPX_INF})
               : f[5] ? (scr[18] ? {s, 31'h0000_0000} : {s, r[30:0]}) : r;
         end
         if (c == FPX_OP_BANK_TOGGLE) scr[21] = ~scr[21];
         if (c == FPX_OP_SIZE_TOGGLE) scr[20] = ~scr[20];
         e[65:64] = {c == FPX_OP_FLOAT_MOVE, scr[20]};
      end
      e[31:0] = scr;
      notes.push_back(e);
      core.issue(c, f, s, r, ~r);
   endtask : run_op

   // Control load: busy span, then the masked value appears
   task automatic do_load(input logic [31:0] v);
      int n;
      n = 0;
      notes.push_back({38'h0, scr});
      core.issue(FPX_OP_CONTROL_LOAD, 12'h000, 1'b0, ~v, v);
      core.idle();
      while (busy === 1'b1 && n < 20) begin
         n++;
         @(negedge ref_clk);
      end
      scr = v & FPX_WR_MASK;
      chk("busy cycles", LC, n);
      chk("loaded value", scr, fpu_status_control_reg);
   endtask : do_load

   // ----------------------------------------------------------------
   // Result watcher
   // ----------------------------------------------------------------
   always @(posedge ref_clk) took_d <= op_valid & ~busy & ~reset;

   // Takes the oldest note whenever a taken op answers
   always @(negedge ref_clk) begin
      logic [69:0] e;
      if (took_d === 1'b1 && notes.size() > 0) begin
         e = notes.pop_front();
         chk("pulses", e[69:65], pulses);
         if (e[66]) chk("dest value", e[63:32], dest_value);
         if (e[65]) chk("move pair", e[64], move_pair);
         chk("status reg", e[31:0], fpu_status_control_reg);
         chk("fields", {e[21:20], e[18], e[1:0]}, {bank_select_bit, pair_transfer_size_bit,
            denormal_flush_mode, rounding_field});
      end else if (took_d !== 1'b1) begin
         chk("idle pulses", 5'h00, pulses);
      end
   end

   // ----------------------------------------------------------------
   // Stimulus
   // ----------------------------------------------------------------
   initial begin
      logic [31:0] q, v;
      logic [11:0] f;
      fpx_op_type c;
      failures = 0;
      cmp_count = 0;
      seed = 32'h8e60;
      scr = FPX_RESET;
      reset = 1'b1;
      repeat (8) @(negedge ref_clk);
      reset = 1'b0;
      chk("reset value", FPX_RESET, fpu_status_control_reg);
      for (int k = 0; k < 10; k++) begin
         v = $random(seed) & FPX_WR_MASK;
         v[1] = 1'b0;
         if (k == 0) v = 32'h0000_0001;
         do_load(v);
         for (int i = 0; i < 16; i++) begin
            c = fpx_op_type'((i % 8 == 6) ? 0 : i % 8);
            q = $random(seed);
            f = q[11:0];
            f[11] = &q[14:12];
            f[9] = f[9] & q[15];
            f[8] = f[8] & q[17];
            f[7] = f[7] & (c == FPX_OP_DIVIDE);
            f[3] = f[3] | f[6];
            f[2] = f[2] | f[5];
            f[1] = f[1] | (|f[6:4]);
            run_op(c, f, q[16] & ~f[8], $random(seed));
         end
      end
      core.idle();
      repeat (3) @(negedge ref_clk);
      chk("notes left", 0, notes.size());
      give_verdict();
   end

   // Cut a hang short well beyond the expected run
   initial begin
      #50000;
      failures++;
      give_verdict();
   end
endmodule : fpx_exception_unit_tb
